// ==== verilog/cic_pkg.sv ====
// Constants shared by the core interrupt control block: register offsets,
// field positions, reset values, bus answer codes and the sequencer states.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`default_nettype none

package cic_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_IRQ_CONTROL = 8'h00;
	localparam logic [7:0] OFF_PIE_THREE   = 8'h04;
	localparam logic [7:0] OFF_EDGE_SELECT = 8'h08;
	localparam logic [7:0] OFF_CHANGE_RISE = 8'h0c;
	localparam logic [7:0] OFF_CHANGE_FALL = 8'h10;
	localparam logic [7:0] OFF_CHANGE_FLAG = 8'h14;
	localparam logic [7:0] OFF_SHADOW_ACC  = 8'h18;
	localparam logic [7:0] OFF_SHADOW_STAT = 8'h1c;
	localparam logic [7:0] OFF_SHADOW_BANK = 8'h20;
	localparam logic [7:0] OFF_SHADOW_FSR  = 8'h24;
	localparam logic [7:0] OFF_SHADOW_PCH  = 8'h28;
	localparam logic [7:0] OFF_CORE_STATE  = 8'h2c;

	// irq_control field positions
	localparam int BIT_GIE   = 7;
	localparam int BIT_PERIPHERAL_IRQ_ENABLE  = 6;
	localparam int BIT_T0IE  = 5;
	localparam int BIT_EXTIE = 4;
	localparam int BIT_PCIE  = 3;
	localparam int BIT_T0IF  = 2;
	localparam int BIT_EXTIF = 1;
	localparam int BIT_PCIF  = 0;

	// peripheral_irq_enable_three field positions
	localparam int BIT_CELL2_IE = 1;
	localparam int BIT_CELL1_IE = 0;

	// Edge select register field position
	localparam int BIT_EDGE_SEL = 0;

	// Core state register field positions
	localparam int BIT_ST_SLEEP = 0;
	localparam int BIT_ST_STEP  = 1;
	localparam int BIT_ST_REQ   = 2;

	// Status bits never saved or restored: timeout and powerdown
	localparam logic [7:0] STATUS_KEEP_MASK = 8'h18;

	// Reset values
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [5:0]  RST_PINS = 6'h00;
	localparam logic [1:0]  RST_CELL = 2'h0;
	localparam logic [4:0]  RST_BANK = 5'h00;
	localparam logic [6:0]  RST_PCH  = 7'h00;
	localparam logic [14:0] RST_PC   = 15'h0000;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// AXI answer codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_SLEEP,
		ST_WAKE_STEP
	} cic_state_type;

endpackage : cic_pkg

`default_nettype wire

// ==== verilog/cic_top.sv ====
// Core interrupt control: interrupt gates, flags, external edge and pin-change
// detection, sleep wake and context shadowing, reached over AXI4-Lite.
// Assumes the core sequencer pulses its events for one aclk cycle and that the
// pins are asynchronous to aclk.
//
// Overview of operation
// - Only clockless sources enabled before sleep entry can wake the device; cell enables are read live during sleep if any was set at entry.
// - After wake, vector only if global enable set; otherwise continue after sleep.
// - Instruction after sleep always retires before any vector branch.
// - External pin gives an edge-triggered request, enabled by ext_pin_irq_enable.
// - ext_edge_select high picks rising edge, low picks falling edge.
// - Valid pin edge sets ext_pin_irq_flag; vectors when both enables set.
// - Interrupt entry pushes the return program counter onto the stack.
// - Entry copies accumulator, status (less two bits), bank, fsr, pc high.
// - Return restores the shadow copies, discarding changes made inside.
// - Shadow copies are software readable and writable; written value is restored.
// - global_irq_enable at bit 7 gates every interrupt.
// - peripheral_irq_enable at bit 6 gates every peripheral interrupt.
// - Remaining irq_control bits: enables at 5..3, flags at 2..0.
// - timer0 overflow sets timer0_overflow_flag.
// - Flags set on their condition regardless of any enable.
// - pin_change_irq_flag is read-only, the OR of all per-pin flags.
// - Third enable register: cell2 enable bit 1, cell1 bit 0, rest zero.
// - Per-pin flag sets on an enabled rising or enabled falling edge.
`default_nettype none

module cic_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        timer0_overflow,
	input  wire logic        ext_pin,
	input  wire logic [5:0]  change_pins,
	input  wire logic [1:0]  logic_cell_irq,
	input  wire logic        core_sleep_enter,
	input  wire logic        core_instr_done,
	input  wire logic        core_irq_enter,
	input  wire logic        core_irq_return,
	input  wire logic [14:0] core_pc,
	input  wire logic [7:0]  core_acc,
	input  wire logic [7:0]  core_status,
	input  wire logic [4:0]  core_bsr,
	input  wire logic [31:0] core_fsr,
	input  wire logic [6:0]  core_pc_high_latch,
	output logic             irq_vector_request,
	output logic             wake_request,
	output logic             sleeping,
	output logic             stack_push,
	output logic [14:0]      stack_push_pc,
	output logic             ctx_restore,
	output logic [7:0]       restore_acc,
	output logic [7:0]       restore_status,
	output logic [4:0]       restore_bsr,
	output logic [31:0]      restore_fsr,
	output logic [6:0]       restore_pc_high_latch
);

	// Bus slave state
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// Register contents
	logic [7:0]  irq_control;
	logic [1:0]  pie_three;
	logic        edge_select;
	logic [5:0]  change_rise;
	logic [5:0]  change_fall;
	logic [5:0]  change_flags;
	logic [7:0]  shadow_acc;
	logic [7:0]  shadow_status;
	logic [4:0]  shadow_bsr;
	logic [31:0] shadow_fsr;
	logic [6:0]  shadow_pc_high_latch;

	// Synchronisers and edge history
	logic        ext_s1;
	logic        ext_s2;
	logic        ext_prev;
	logic [5:0]  pin_s1;
	logic [5:0]  pin_s2;
	logic [5:0]  pin_prev;

	// Sequencer and wake snapshot
	cic_pkg::cic_state_type state;
	cic_pkg::cic_state_type next_state;
	logic [3:0]  wake_snap;

	// Write decode
	wire wr_fire   = aw_held && w_held && !s_axi_bvalid;
	wire lane0     = w_strb[0];
	wire we_ctrl   = wr_fire && lane0 && (aw_addr == cic_pkg::OFF_IRQ_CONTROL);
	wire we_peripheral_irq_enable_three   = wr_fire && lane0 && (aw_addr == cic_pkg::OFF_PIE_THREE);
	wire we_edge   = wr_fire && lane0 && (aw_addr == cic_pkg::OFF_EDGE_SELECT);
	wire we_rise   = wr_fire && lane0 && (aw_addr == cic_pkg::OFF_CHANGE_RISE);
	wire we_fall   = wr_fire && lane0 && (aw_addr == cic_pkg::OFF_CHANGE_FALL);
	wire we_cflag  = wr_fire && lane0 && (aw_addr == cic_pkg::OFF_CHANGE_FLAG);
	wire we_sacc   = wr_fire && lane0 && (aw_addr == cic_pkg::OFF_SHADOW_ACC);
	wire we_sstat  = wr_fire && lane0 && (aw_addr == cic_pkg::OFF_SHADOW_STAT);
	wire we_sbank  = wr_fire && lane0 && (aw_addr == cic_pkg::OFF_SHADOW_BANK);
	wire we_sfsr   = wr_fire && (aw_addr == cic_pkg::OFF_SHADOW_FSR);
	wire we_spch   = wr_fire && lane0 && (aw_addr == cic_pkg::OFF_SHADOW_PCH);
	wire wr_mapped = (aw_addr == cic_pkg::OFF_IRQ_CONTROL) || (aw_addr == cic_pkg::OFF_PIE_THREE)
		|| (aw_addr == cic_pkg::OFF_EDGE_SELECT) || (aw_addr == cic_pkg::OFF_CHANGE_RISE)
		|| (aw_addr == cic_pkg::OFF_CHANGE_FALL) || (aw_addr == cic_pkg::OFF_CHANGE_FLAG)
		|| (aw_addr == cic_pkg::OFF_SHADOW_ACC) || (aw_addr == cic_pkg::OFF_SHADOW_STAT)
		|| (aw_addr == cic_pkg::OFF_SHADOW_BANK) || (aw_addr == cic_pkg::OFF_SHADOW_FSR)
		|| (aw_addr == cic_pkg::OFF_SHADOW_PCH) || (aw_addr == cic_pkg::OFF_CORE_STATE);

	// Source conditions
	wire global_irq_enable        = irq_control[cic_pkg::BIT_GIE];
	wire peripheral_irq_enable       = irq_control[cic_pkg::BIT_PERIPHERAL_IRQ_ENABLE];
	wire t0_flag    = irq_control[cic_pkg::BIT_T0IF];
	wire ext_flag   = irq_control[cic_pkg::BIT_EXTIF];
	wire pc_flag    = |change_flags;
	wire ext_hit    = edge_select ? (ext_s2 && !ext_prev) : (!ext_s2 && ext_prev);
	wire [5:0] pin_hit = (change_rise & pin_s2 & ~pin_prev) | (change_fall & ~pin_s2 & pin_prev);
	wire core_pending = (t0_flag && irq_control[cic_pkg::BIT_T0IE])
		|| (ext_flag && irq_control[cic_pkg::BIT_EXTIE])
		|| (pc_flag && irq_control[cic_pkg::BIT_PCIE]);
	wire periph_pending = peripheral_irq_enable && |(logic_cell_irq & pie_three);
	// clockless sources only; ext and pin-change enables as captured at sleep entry, cell enables live if any was set then
	wire wake_source = (ext_flag && wake_snap[0]) || (pc_flag && wake_snap[1])
		|| (wake_snap[2] && |(logic_cell_irq & (wake_snap[3] ? pie_three : cic_pkg::RST_CELL)));

	// request to core, global gate, sequencing
	assign irq_vector_request = global_irq_enable && (core_pending || periph_pending) && (state == cic_pkg::ST_RUN);
	assign wake_request       = (state == cic_pkg::ST_SLEEP) && wake_source;
	assign sleeping           = (state == cic_pkg::ST_SLEEP);

	// Read decode
	wire [31:0] rd_word =
		(s_axi_araddr == cic_pkg::OFF_IRQ_CONTROL) ? {24'h000000, irq_control[7:1], pc_flag} :
		(s_axi_araddr == cic_pkg::OFF_PIE_THREE)   ? {30'h00000000, pie_three} :
		(s_axi_araddr == cic_pkg::OFF_EDGE_SELECT) ? {31'h00000000, edge_select} :
		(s_axi_araddr == cic_pkg::OFF_CHANGE_RISE) ? {26'h0000000, change_rise} :
		(s_axi_araddr == cic_pkg::OFF_CHANGE_FALL) ? {26'h0000000, change_fall} :
		(s_axi_araddr == cic_pkg::OFF_CHANGE_FLAG) ? {26'h0000000, change_flags} :
		(s_axi_araddr == cic_pkg::OFF_SHADOW_ACC)  ? {24'h000000, shadow_acc} :
		(s_axi_araddr == cic_pkg::OFF_SHADOW_STAT) ? {24'h000000, shadow_status} :
		(s_axi_araddr == cic_pkg::OFF_SHADOW_BANK) ? {27'h0000000, shadow_bsr} :
		(s_axi_araddr == cic_pkg::OFF_SHADOW_FSR)  ? shadow_fsr :
		(s_axi_araddr == cic_pkg::OFF_SHADOW_PCH)  ? {25'h0000000, shadow_pc_high_latch} :
		(s_axi_araddr == cic_pkg::OFF_CORE_STATE)  ?
			{29'h00000000, irq_vector_request, state == cic_pkg::ST_WAKE_STEP, sleeping} :
		cic_pkg::RST_WORD;
	wire rd_mapped = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= cic_pkg::OFF_CORE_STATE);

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// Write channel capture, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= cic_pkg::RST_BYTE;
			w_data       <= cic_pkg::RST_WORD;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= cic_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? cic_pkg::RESP_OKAY : cic_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= cic_pkg::RST_WORD;
			s_axi_rresp  <= cic_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mapped ? rd_word : cic_pkg::RST_WORD;
			s_axi_rresp  <= rd_mapped ? cic_pkg::RESP_OKAY : cic_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_s1   <= 1'b0;
			ext_s2   <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			ext_s1   <= ext_pin;
			ext_s2   <= ext_s1;
			ext_prev <= ext_s2;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_pin
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pin_s1[gi]       <= 1'b0;
					pin_s2[gi]       <= 1'b0;
					pin_prev[gi]     <= 1'b0;
					change_flags[gi] <= 1'b0;
				end else begin
					pin_s1[gi]       <= change_pins[gi];
					pin_s2[gi]       <= pin_s1[gi];
					pin_prev[gi]     <= pin_s2[gi];
					change_flags[gi] <= (we_cflag ? w_data[gi] : change_flags[gi]) | pin_hit[gi];
				end
			end
		end
	endgenerate

	// enable layout, flags set regardless of enables, set wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_control <= cic_pkg::RST_BYTE;
		end else begin
			if (core_irq_enter) begin
				irq_control[cic_pkg::BIT_GIE] <= 1'b0;
			end else if (core_irq_return) begin
				irq_control[cic_pkg::BIT_GIE] <= 1'b1;
			end else if (we_ctrl) begin
				irq_control[cic_pkg::BIT_GIE] <= w_data[cic_pkg::BIT_GIE];
			end
			if (we_ctrl) begin
				irq_control[cic_pkg::BIT_PERIPHERAL_IRQ_ENABLE]  <= w_data[cic_pkg::BIT_PERIPHERAL_IRQ_ENABLE];
				irq_control[cic_pkg::BIT_T0IE]  <= w_data[cic_pkg::BIT_T0IE];
				irq_control[cic_pkg::BIT_EXTIE] <= w_data[cic_pkg::BIT_EXTIE];
				irq_control[cic_pkg::BIT_PCIE]  <= w_data[cic_pkg::BIT_PCIE];
			end
			irq_control[cic_pkg::BIT_T0IF] <= (we_ctrl ? w_data[cic_pkg::BIT_T0IF] : t0_flag) | timer0_overflow;
			irq_control[cic_pkg::BIT_EXTIF] <= (we_ctrl ? w_data[cic_pkg::BIT_EXTIF] : ext_flag) | ext_hit;
			irq_control[cic_pkg::BIT_PCIF]  <= 1'b0;
		end
	end

	// logic cell enables and other configuration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pie_three   <= cic_pkg::RST_CELL;
			edge_select <= 1'b0;
			change_rise <= cic_pkg::RST_PINS;
			change_fall <= cic_pkg::RST_PINS;
		end else begin
			if (we_peripheral_irq_enable_three) begin
				pie_three <= {w_data[cic_pkg::BIT_CELL2_IE], w_data[cic_pkg::BIT_CELL1_IE]};
			end
			if (we_edge) begin
				edge_select <= w_data[cic_pkg::BIT_EDGE_SEL];
			end
			if (we_rise) begin
				change_rise <= w_data[5:0];
			end
			if (we_fall) begin
				change_fall <= w_data[5:0];
			end
		end
	end

	// save on entry, software access; entry wins a same-cycle write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shadow_acc    <= cic_pkg::RST_BYTE;
			shadow_status <= cic_pkg::RST_BYTE;
			shadow_bsr    <= cic_pkg::RST_BANK;
			shadow_fsr    <= cic_pkg::RST_WORD;
			shadow_pc_high_latch <= cic_pkg::RST_PCH;
		end else if (core_irq_enter) begin
			shadow_acc    <= core_acc;
			shadow_status <= core_status & ~cic_pkg::STATUS_KEEP_MASK;
			shadow_bsr    <= core_bsr;
			shadow_fsr    <= core_fsr;
			shadow_pc_high_latch <= core_pc_high_latch;
		end else begin
			if (we_sacc) begin
				shadow_acc <= w_data[7:0];
			end
			if (we_sstat) begin
				shadow_status <= w_data[7:0] & ~cic_pkg::STATUS_KEEP_MASK;
			end
			if (we_sbank) begin
				shadow_bsr <= w_data[4:0];
			end
			for (int b = 0; b < 4; b++) begin
				if (we_sfsr && w_strb[b]) begin
					shadow_fsr[b*8 +: 8] <= w_data[b*8 +: 8];
				end
			end
			if (we_spch) begin
				shadow_pc_high_latch <= w_data[6:0];
			end
		end
	end

	// stack push and restore pulses with their data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stack_push     <= 1'b0;
			stack_push_pc  <= cic_pkg::RST_PC;
			ctx_restore    <= 1'b0;
			restore_acc    <= cic_pkg::RST_BYTE;
			restore_status <= cic_pkg::RST_BYTE;
			restore_bsr    <= cic_pkg::RST_BANK;
			restore_fsr    <= cic_pkg::RST_WORD;
			restore_pc_high_latch <= cic_pkg::RST_PCH;
		end else begin
			stack_push  <= core_irq_enter;
			ctx_restore <= core_irq_return;
			if (core_irq_enter) begin
				stack_push_pc <= core_pc;
			end
			if (core_irq_return) begin
				restore_acc    <= shadow_acc;
				restore_status <= shadow_status;
				restore_bsr    <= shadow_bsr;
				restore_fsr    <= shadow_fsr;
				restore_pc_high_latch <= shadow_pc_high_latch;
			end
		end
	end

	// wake sequencer, one instruction before vector
	always_comb begin
		next_state = state;
		unique case (state)
			cic_pkg::ST_RUN:       if (core_sleep_enter) next_state = cic_pkg::ST_SLEEP;
			cic_pkg::ST_SLEEP:     if (wake_source) next_state = cic_pkg::ST_WAKE_STEP;
			cic_pkg::ST_WAKE_STEP: if (core_instr_done) next_state = cic_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state     <= cic_pkg::ST_RUN;
			wake_snap <= 4'h0;
		end else begin
			state <= next_state;
			if (state == cic_pkg::ST_RUN && core_sleep_enter) begin
				wake_snap <= {|pie_three, peripheral_irq_enable, irq_control[cic_pkg::BIT_PCIE], irq_control[cic_pkg::BIT_EXTIE]};
			end
		end
	end

	t0_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		timer0_overflow |=> t0_flag) else $error("overflow did not set timer0 flag");

	set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(we_ctrl && !w_data[cic_pkg::BIT_T0IF] && timer0_overflow && !irq_control[cic_pkg::BIT_T0IE])
		|=> t0_flag) else $error("flag set lost against clear");

	ext_edge_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(edge_select && ext_s2 && !ext_prev) |=> ext_flag) else $error("rising edge missed");

	pin_change_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(|(change_fall & ~pin_s2 & pin_prev)) |=> pc_flag) else $error("falling pin change missed");

	global_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!global_irq_enable |-> !irq_vector_request) else $error("request while globally disabled");

	periph_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!peripheral_irq_enable && !core_pending) |-> !irq_vector_request) else $error("peripheral request without gate");

	wake_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(state == cic_pkg::ST_WAKE_STEP) |-> !irq_vector_request throughout
		(state == cic_pkg::ST_WAKE_STEP)[*1]) else $error("vector before post-sleep instruction");

	timer_no_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(sleeping && !ext_flag && !pc_flag && !(|logic_cell_irq)) |-> !wake_request)
		else $error("wake from a clocked source");

	shadow_save_a: assert property (@(posedge aclk) disable iff (!aresetn)
		core_irq_enter |=> (shadow_acc == $past(core_acc)) && (shadow_bsr == $past(core_bsr)))
		else $error("context not saved on entry");

	push_pc_a: assert property (@(posedge aclk) disable iff (!aresetn)
		core_irq_enter |=> stack_push && (stack_push_pc == $past(core_pc))) else $error("return pc not pushed");

	restore_ctx_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(core_irq_return && !core_irq_enter) |=> ctx_restore && (restore_acc == $past(shadow_acc))
		&& (restore_pc_high_latch == $past(shadow_pc_high_latch))) else $error("context not restored");

endmodule : cic_top

`default_nettype wire

// ==== dv/cic_core_model.sv ====
// Processor core stand-in: takes vectors, sleeps and returns on command.
// Assumes the bench pulses sleep_cmd and ret_cmd for one aclk cycle.
`default_nettype none

module cic_core_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        irq_vector_request,
	input  wire logic        wake_request,
	input  wire logic        take_en,
	input  wire logic        sleep_cmd,
	input  wire logic        ret_cmd,
	input  wire logic [7:0]  ctx,
	output logic             core_sleep_enter,
	output logic             core_instr_done,
	output logic             core_irq_enter,
	output logic             core_irq_return,
	output logic [14:0]      core_pc,
	output logic [7:0]       core_acc,
	output logic [7:0]       core_status,
	output logic [4:0]       core_bsr,
	output logic [31:0]      core_fsr,
	output logic [6:0]       core_pc_high_latch
);
	timeunit 1ns;
	timeprecision 1ps;
	logic woke;
	assign core_pc     = {ctx, ctx[6:0]};
	assign core_acc    = ctx;
	assign core_status = ctx;
	assign core_bsr    = ctx[4:0];
	assign core_fsr    = {4{ctx}};
	assign core_pc_high_latch = ctx[6:0];
	always_ff @(posedge aclk) begin
		core_sleep_enter <= sleep_cmd;
		core_irq_return  <= ret_cmd;
		// Single pulse per vector, the request drops once the entry lands
		core_irq_enter   <= take_en & irq_vector_request & ~core_irq_enter;
		core_instr_done  <= woke;
		woke             <= wake_request & ~woke & aresetn;
	end
endmodule : cic_core_model

`default_nettype wire

// ==== dv/cic_top_test.sv ====
// Self-checking bench for the core interrupt control block.
// Assumes cic_pkg, cic_top and the core model cic_core_model.
`default_nettype none

module cic_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic        t0_ovf = 1'b0, ext_pin = 1'b0, take_en = 1'b0, sleep_cmd = 1'b0, ret_cmd = 1'b0;
	logic [5:0]  pins = 6'h00;
	logic [1:0]  cells = 2'h0;
	logic [7:0]  ctx = 8'h4f;
	logic [7:0]  seed = 8'h4f;
	logic [31:0] d;
	logic [1:0]  r;
	logic [5:0]  rise, fall, nxt, expf;
	logic        step;
	int          n, bad_count = 0, tests_run = 0, cycles = 0;
	wire logic   awready, wready, bvalid, arready, rvalid, vec, wake, sleeping, push, restore;
	wire logic   c_sleep, c_done, c_enter, c_ret;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata, c_fsr, rfsr;
	wire logic [14:0] c_pc, push_pc;
	wire logic [7:0]  c_acc, c_stat, racc, rstat;
	wire logic [4:0]  c_bsr, rbsr;
	wire logic [6:0]  c_pch, rpch;

	cic_top i_cic_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(1'b1), .timer0_overflow(t0_ovf), .ext_pin(ext_pin), .change_pins(pins),
		.logic_cell_irq(cells), .core_sleep_enter(c_sleep), .core_instr_done(c_done),
		.core_irq_enter(c_enter), .core_irq_return(c_ret), .core_pc(c_pc), .core_acc(c_acc),
		.core_status(c_stat), .core_bsr(c_bsr), .core_fsr(c_fsr), .core_pc_high_latch(c_pch),
		.irq_vector_request(vec), .wake_request(wake), .sleeping(sleeping), .stack_push(push),
		.stack_push_pc(push_pc), .ctx_restore(restore), .restore_acc(racc), .restore_status(rstat),
		.restore_bsr(rbsr), .restore_fsr(rfsr), .restore_pc_high_latch(rpch));
	cic_core_model i_cic_core_model (.aclk(aclk), .aresetn(aresetn), .irq_vector_request(vec),
		.wake_request(wake), .take_en(take_en), .sleep_cmd(sleep_cmd), .ret_cmd(ret_cmd), .ctx(ctx),
		.core_sleep_enter(c_sleep), .core_instr_done(c_done), .core_irq_enter(c_enter),
		.core_irq_return(c_ret), .core_pc(c_pc), .core_acc(c_acc), .core_status(c_stat),
		.core_bsr(c_bsr), .core_fsr(c_fsr), .core_pc_high_latch(c_pch));

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr_next
	function automatic logic [5:0] change_exp(input logic [5:0] re, fe, o, nw);
		return (re & ~o & nw) | (fe & o & ~nw);
	endfunction : change_exp
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report
	task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk32
	task automatic chk1(input string nm, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask : chk1
	// Ready is sampled at the falling edge, it cannot change before the next rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [2:0] hs;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(negedge aclk);
			hs = {awvalid & awready, wvalid & wready, bvalid};
			@(posedge aclk);
			if (hs[2]) awvalid <= 1'b0;
			if (hs[1]) wvalid <= 1'b0;
		end while (!hs[0]);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic [1:0] hs;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			hs = {arvalid & arready, rvalid};
			v = rdata;
			rs = rresp;
			@(posedge aclk);
			if (hs[1]) arvalid <= 1'b0;
		end while (!hs[0]);
	endtask : rd

	initial begin
		forever #12.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			final_report();
		end
	end

	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(cic_pkg::OFF_IRQ_CONTROL, d, r);
		chk32("irq_control reset", 32'h0, d);
		rd(cic_pkg::OFF_PIE_THREE, d, r);
		chk32("pie three reset", 32'h0, d);
		wr(cic_pkg::OFF_PIE_THREE, 32'hff);
		rd(cic_pkg::OFF_PIE_THREE, d, r);
		chk32("pie three bits", 32'h03, d);
		wr(cic_pkg::OFF_IRQ_CONTROL, 32'hff);
		rd(cic_pkg::OFF_IRQ_CONTROL, d, r);
		chk32("irq_control bits", 32'hfe, d);
		wr(cic_pkg::OFF_PIE_THREE, 32'h0);
		wr(cic_pkg::OFF_IRQ_CONTROL, 32'h0);
		rd(8'h30, d, r);
		chk32("unmapped resp", {30'h0, cic_pkg::RESP_SLVERR}, {30'h0, r});
		$display("test registers done");
		t0_ovf <= 1'b1;
		@(posedge aclk);
		t0_ovf <= 1'b0;
		rd(cic_pkg::OFF_IRQ_CONTROL, d, r);
		chk32("timer flag", 32'h04, d);
		chk1("vector gated", 1'b0, vec);
		wr(cic_pkg::OFF_IRQ_CONTROL, 32'ha4);
		@(negedge aclk);
		chk1("vector open", 1'b1, vec);
		take_en <= 1'b1;
		n = 0;
		while (push !== 1'b1 && n < 20) begin
			@(negedge aclk);
			n++;
		end
		take_en <= 1'b0;
		chk32("pushed pc", {17'h0, ctx, ctx[6:0]}, {17'h0, push_pc});
		rd(cic_pkg::OFF_SHADOW_ACC, d, r);
		chk32("shadow acc", {24'h0, ctx}, d);
		rd(cic_pkg::OFF_SHADOW_STAT, d, r);
		chk32("shadow status", {24'h0, ctx & ~8'h18}, d);
		seed = lfsr_next(seed);
		wr(cic_pkg::OFF_SHADOW_ACC, {24'h0, seed});
		ctx <= ~ctx;
		ret_cmd <= 1'b1;
		@(posedge aclk);
		ret_cmd <= 1'b0;
		n = 0;
		while (restore !== 1'b1 && n < 20) begin
			@(negedge aclk);
			n++;
		end
		chk32("restored acc", {24'h0, seed}, {24'h0, racc});
		chk32("restored fsr", {4{~ctx}}, rfsr);
		chk32("restored status", 32'h0, {24'h0, rstat & 8'h18});
		wr(cic_pkg::OFF_IRQ_CONTROL, 32'h0);
		$display("test context done");
		for (int i = 0; i < 8; i++) begin
			seed = lfsr_next(seed);
			rise = seed[5:0];
			seed = lfsr_next(seed);
			fall = seed[5:0];
			seed = lfsr_next(seed);
			nxt = (i == 0) ? ~pins : seed[5:0];
			wr(cic_pkg::OFF_CHANGE_RISE, {26'h0, rise});
			wr(cic_pkg::OFF_CHANGE_FALL, {26'h0, fall});
			wr(cic_pkg::OFF_CHANGE_FLAG, 32'h0);
			wr(cic_pkg::OFF_IRQ_CONTROL, 32'h01);
			expf = change_exp(rise, fall, pins, nxt);
			pins <= nxt;
			repeat (4) @(posedge aclk);
			rd(cic_pkg::OFF_CHANGE_FLAG, d, r);
			chk32("change flags", {26'h0, expf}, d);
			rd(cic_pkg::OFF_IRQ_CONTROL, d, r);
			chk32("change summary", {31'h0, |expf}, d);
		end
		wr(cic_pkg::OFF_CHANGE_FLAG, 32'h0);
		$display("test pin change done");
		for (int e = 1; e >= 0; e--) begin
			wr(cic_pkg::OFF_EDGE_SELECT, {31'h0, e[0]});
			ext_pin <= ~e[0];
			repeat (4) @(posedge aclk);
			wr(cic_pkg::OFF_IRQ_CONTROL, 32'h0);
			ext_pin <= e[0];
			repeat (4) @(posedge aclk);
			rd(cic_pkg::OFF_IRQ_CONTROL, d, r);
			chk32("edge taken", 32'h02, d);
			wr(cic_pkg::OFF_IRQ_CONTROL, 32'h0);
			ext_pin <= ~e[0];
			repeat (4) @(posedge aclk);
			rd(cic_pkg::OFF_IRQ_CONTROL, d, r);
			chk32("edge ignored", 32'h0, d);
		end
		$display("test ext edge done");
		wr(cic_pkg::OFF_PIE_THREE, 32'h01);
		cells <= 2'b01;
		wr(cic_pkg::OFF_IRQ_CONTROL, 32'h80);
		repeat (2) @(negedge aclk);
		chk1("peripheral_irq_enable closed", 1'b0, vec);
		wr(cic_pkg::OFF_IRQ_CONTROL, 32'hc0);
		repeat (2) @(negedge aclk);
		chk1("peripheral_irq_enable open", 1'b1, vec);
		cells <= 2'b10;
		repeat (2) @(negedge aclk);
		chk1("cell two masked", 1'b0, vec);
		cells <= 2'b00;
		wr(cic_pkg::OFF_PIE_THREE, 32'h0);
		wr(cic_pkg::OFF_IRQ_CONTROL, 32'hb0);
		$display("test peripheral gate done");
		sleep_cmd <= 1'b1;
		@(posedge aclk);
		sleep_cmd <= 1'b0;
		repeat (2) @(negedge aclk);
		chk1("asleep", 1'b1, sleeping);
		t0_ovf <= 1'b1;
		@(posedge aclk);
		t0_ovf <= 1'b0;
		repeat (2) @(negedge aclk);
		chk1("timer no wake", 1'b0, wake);
		chk1("no vector asleep", 1'b0, vec);
		take_en <= 1'b1;
		step = 1'b0;
		ext_pin <= 1'b0;
		n = 0;
		while (c_enter !== 1'b1 && n < 40) begin
			@(negedge aclk);
			if (c_done === 1'b1) step = 1'b1;
			n++;
		end
		take_en <= 1'b0;
		chk1("vector after wake", 1'b1, c_enter);
		chk1("step before vector", 1'b1, step);
		$display("test sleep wake done");
		final_report();
	end
endmodule : cic_top_test

`default_nettype wire
